/* rtl/tsg_link_if.sv */
// Register link between the tone controller and the tone generator.
`timescale 1ns/1ns
interface tsg_link_if;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;

  modport device (input reg_addr, input reg_wdata, input reg_wr, input reg_rd, output reg_rdata);
  modport host (output reg_addr, output reg_wdata, output reg_wr, output reg_rd, input reg_rdata);
endinterface

/* rtl/tsg_pkg.sv */
// Shared constants and types for the sine tone generator and its controller.
package tsg_pkg;

  // Data widths.
  localparam int TSG_REG_W    = 8;
  localparam int TSG_SAMPLE_W = 16;
  localparam int TSG_LEN_W    = 24;
  localparam int TSG_COEF_W   = 16;
  localparam int TSG_LEVEL_W  = 6;
  localparam int TSG_SW_W     = 32;

  // Tone register offsets on the link.
  localparam logic [7:0] TSG_OFS_LEFT_CTL  = 8'h47;
  localparam logic [7:0] TSG_OFS_RIGHT_CTL = 8'h48;
  localparam logic [7:0] TSG_OFS_LEN_HI    = 8'h49;
  localparam logic [7:0] TSG_OFS_LEN_MID   = 8'h4A;
  localparam logic [7:0] TSG_OFS_LEN_LO    = 8'h4B;
  localparam logic [7:0] TSG_OFS_SIN_HI    = 8'h4C;
  localparam logic [7:0] TSG_OFS_SIN_LO    = 8'h4D;
  localparam logic [7:0] TSG_OFS_COS_HI    = 8'h4E;
  localparam logic [7:0] TSG_OFS_COS_LO    = 8'h4F;
  localparam logic [3:0] TSG_CFG_COUNT     = 4'h9;

  // Tone register reset values; level 0 is the loudest setting.
  localparam logic [7:0] TSG_RST_CTL     = 8'h00;
  localparam logic [7:0] TSG_RST_LEN_HI  = 8'h00;
  localparam logic [7:0] TSG_RST_LEN_MID = 8'h00;
  localparam logic [7:0] TSG_RST_LEN_LO  = 8'hEE;
  localparam logic [7:0] TSG_RST_SIN_HI  = 8'h10;
  localparam logic [7:0] TSG_RST_SIN_LO  = 8'hD8;
  localparam logic [7:0] TSG_RST_COS_HI  = 8'h7E;
  localparam logic [7:0] TSG_RST_COS_LO  = 8'hE3;

  // Control field positions.
  localparam int TSG_ENABLE_BIT = 7;
  localparam int TSG_LEVEL_MSB  = 5;
  localparam int TSG_MASTER_LSB = 6;
  localparam int TSG_MASTER_MSB = 7;

  // Level arithmetic: one code is one decibel, six codes halve the gain.
  localparam logic [5:0] TSG_DB_PER_HALVING = 6'h06;
  localparam int         TSG_GAIN_FRAC      = 14;
  localparam int         TSG_OSC_FRAC       = 14;

  typedef enum logic [1:0] {
    TSG_MASTER_INDEP,
    TSG_MASTER_LEFT,
    TSG_MASTER_RIGHT,
    TSG_MASTER_MUTE
  } tsg_master_e;

  // Controller register offsets on the software port.
  localparam logic [7:0] TSG_HOST_SINE   = 8'h00;
  localparam logic [7:0] TSG_HOST_COSINE = 8'h04;
  localparam logic [7:0] TSG_HOST_LENGTH = 8'h08;
  localparam logic [7:0] TSG_HOST_VOLUME = 8'h0C;
  localparam logic [7:0] TSG_HOST_CMD    = 8'h10;
  localparam logic [7:0] TSG_HOST_STATUS = 8'h14;
  localparam int TSG_CMD_LOAD_BIT = 0;
  localparam int TSG_CMD_BEEP_BIT = 1;
  localparam int TSG_CMD_POLL_BIT = 2;
  localparam int TSG_VOL_RIGHT_LSB = 8;
  localparam logic [1:0] TSG_GAIN_FLAGS_SET = 2'h3;

  // Gain mantissa for 0..5 dB below the +2 dB top, scaled by 2^14.
  function automatic logic [15:0] tsg_gain_mant(input logic [5:0] r);
    case (r)
      6'h00:   return 16'h5092;
      6'h01:   return 16'h47CF;
      6'h02:   return 16'h4000;
      6'h03:   return 16'h390A;
      6'h04:   return 16'h32D6;
      default: return 16'h2D4F;
    endcase
  endfunction

endpackage

/* rtl/tsg_tone_device.sv */
// Sine tone generator: tone registers, oscillator, burst timer and playback mixer.
// Contract
// - Nine 8-bit registers fully define the tone.
// - Sine coefficient 16 bits, high 0x4C, low 0x4D.
// - Cosine coefficient 16 bits, high 0x4E, low 0x4F.
// - Length 24 bits over 0x49, 0x4A, 0x4B.
// - One length count is one sample.
// - Reset length 0000EE, sine 10D8, cosine 7EE3.
// - Six-bit level, +2 dB to -61 dB.
// - Left level 0x47[5:0], right 0x48[5:0].
// - Master field 0x48[7:6] combines both levels.
// - Both levels reset to +2 dB.
// - Tone mixed after playback volume stage.
// - Host computes coefficients and length in software.
// - Host keeps tone below quarter sample rate.
// - Host zeroes unused coefficient upper bits.
// - Host zeroes unused length upper bits.
// - Host preloads settings, then only triggers.
// - Bit 7 of 0x47 enables the burst.
// - Host mutes, waits, stops divider around enable.
// - Host avoids serial clocks from DAC clocks.
`timescale 1ns/1ns
module tsg_tone_device #(
  parameter int SAMPLE_W = tsg_pkg::TSG_SAMPLE_W
) (
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_in,
  // Register link
  tsg_link_if.device                      link,
  // Playback stream, already through its own volume stage
  input  wire logic                       sample_tick_in,
  input  wire logic signed [SAMPLE_W-1:0] play_left_in,
  input  wire logic signed [SAMPLE_W-1:0] play_right_in,
  // Mixed stream and state
  output logic signed [SAMPLE_W-1:0]      mix_left_out,
  output logic signed [SAMPLE_W-1:0]      mix_right_out,
  output logic                            tone_active_out
);
  import tsg_pkg::*;

  localparam int OW = SAMPLE_W + 2;
  localparam logic signed [OW-1:0] MAXV = OW'(2 ** (SAMPLE_W - 1) - 1);
  localparam logic signed [OW-1:0] MINV = -OW'(2 ** (SAMPLE_W - 1));

  // Clamp a wide sample into the output range.
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [OW-1:0] v);
    if (v > MAXV) begin
      return MAXV[SAMPLE_W-1:0];
    end else if (v < MINV) begin
      return MINV[SAMPLE_W-1:0];
    end else begin
      return v[SAMPLE_W-1:0];
    end
  endfunction

  logic [7:0]                 left_ctl_reg;
  logic [7:0]                 right_ctl_reg;
  logic [7:0]                 len_hi_reg;
  logic [7:0]                 len_mid_reg;
  logic [7:0]                 len_lo_reg;
  logic [7:0]                 sin_hi_reg;
  logic [7:0]                 sin_lo_reg;
  logic [7:0]                 cos_hi_reg;
  logic [7:0]                 cos_lo_reg;
  logic                       enable_reg;
  logic [TSG_LEN_W-1:0]       burst_cnt_reg;
  logic signed [OW-1:0]       y_now_reg;
  logic signed [OW-1:0]       y_prev_reg;
  logic signed [SAMPLE_W-1:0] tone_raw_reg;
  logic [7:0]                 rdata_reg;
  logic [7:0]                 rd_val;
  logic                       wr_left;
  logic                       start;
  logic                       stop_sw;
  logic                       done;
  logic                       emit;
  logic signed [TSG_COEF_W-1:0] sin_coef;
  logic signed [TSG_COEF_W-1:0] cos_coef;
  logic signed [OW+TSG_COEF_W-1:0] osc_prod;
  logic signed [OW-1:0]       y_next;
  logic [5:0]                 left_lvl;
  logic [5:0]                 right_lvl;
  logic                       tone_mute;
  tsg_master_e                master;
  logic signed [SAMPLE_W-1:0] tone_left;
  logic signed [SAMPLE_W-1:0] tone_right;

  assign wr_left  = link.reg_wr && (link.reg_addr == TSG_OFS_LEFT_CTL);
  assign start    = wr_left && link.reg_wdata[TSG_ENABLE_BIT];
  assign stop_sw  = wr_left && !link.reg_wdata[TSG_ENABLE_BIT];
  // A zero count ends the burst at once; a count of one ends with the sample it emits.
  assign done     = enable_reg && ((burst_cnt_reg == '0) ||
                                   (sample_tick_in && (burst_cnt_reg == TSG_LEN_W'(1))));
  assign emit     = enable_reg && sample_tick_in && (burst_cnt_reg != '0);
  assign sin_coef = {sin_hi_reg, sin_lo_reg};
  assign cos_coef = {cos_hi_reg, cos_lo_reg};

  // Stored configuration; the enable bit of the left control lives in enable_reg.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      left_ctl_reg  <= TSG_RST_CTL;
      right_ctl_reg <= TSG_RST_CTL;
      len_hi_reg    <= TSG_RST_LEN_HI;
      len_mid_reg   <= TSG_RST_LEN_MID;
      len_lo_reg    <= TSG_RST_LEN_LO;
      sin_hi_reg    <= TSG_RST_SIN_HI;
      sin_lo_reg    <= TSG_RST_SIN_LO;
      cos_hi_reg    <= TSG_RST_COS_HI;
      cos_lo_reg    <= TSG_RST_COS_LO;
    end else if (link.reg_wr) begin
      case (link.reg_addr)
        TSG_OFS_LEFT_CTL:  left_ctl_reg  <= link.reg_wdata;
        TSG_OFS_RIGHT_CTL: right_ctl_reg <= link.reg_wdata;
        TSG_OFS_LEN_HI:    len_hi_reg    <= link.reg_wdata;
        TSG_OFS_LEN_MID:   len_mid_reg   <= link.reg_wdata;
        TSG_OFS_LEN_LO:    len_lo_reg    <= link.reg_wdata;
        TSG_OFS_SIN_HI:    sin_hi_reg    <= link.reg_wdata;
        TSG_OFS_SIN_LO:    sin_lo_reg    <= link.reg_wdata;
        TSG_OFS_COS_HI:    cos_hi_reg    <= link.reg_wdata;
        TSG_OFS_COS_LO:    cos_lo_reg    <= link.reg_wdata;
        default: ;
      endcase
    end
  end

  // A fresh enable write beats the end of the previous burst in the same cycle.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_reg <= 1'b0;
    end else if (start) begin
      enable_reg <= 1'b1;
    end else if (stop_sw || done) begin
      enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      burst_cnt_reg <= '0;
    end else if (start) begin
      burst_cnt_reg <= {len_hi_reg, len_mid_reg, len_lo_reg};
    end else if (emit) begin
      burst_cnt_reg <= burst_cnt_reg - TSG_LEN_W'(1);
    end
  end

  // y[n+1] = 2*cos*y[n] - y[n-1]; seeding y[-1] = -sin starts the wave at zero phase.
  assign osc_prod = $signed(cos_coef) * y_now_reg;
  assign y_next   = OW'(osc_prod >>> TSG_OSC_FRAC) - y_prev_reg;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      y_now_reg  <= '0;
      y_prev_reg <= '0;
    end else if (start) begin
      y_now_reg  <= '0;
      y_prev_reg <= -OW'(sin_coef);
    end else if (emit) begin
      y_now_reg  <= y_next;
      y_prev_reg <= y_now_reg;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tone_raw_reg <= '0;
    end else if (sample_tick_in) begin
      tone_raw_reg <= emit ? sat(y_now_reg) : '0;
    end
  end

  // Master field decides which level each side uses.
  always_comb begin
    master    = tsg_master_e'(right_ctl_reg[TSG_MASTER_MSB:TSG_MASTER_LSB]);
    left_lvl  = left_ctl_reg[TSG_LEVEL_MSB:0];
    right_lvl = right_ctl_reg[TSG_LEVEL_MSB:0];
    tone_mute = 1'b0;
    case (master)
      TSG_MASTER_INDEP: ;
      TSG_MASTER_LEFT:  right_lvl = left_ctl_reg[TSG_LEVEL_MSB:0];
      TSG_MASTER_RIGHT: left_lvl  = right_ctl_reg[TSG_LEVEL_MSB:0];
      TSG_MASTER_MUTE:  tone_mute = 1'b1;
      default: ;
    endcase
  end

  tsg_tone_scale #(
    .SAMPLE_W (SAMPLE_W)
  ) u_scale_left (
    .core_clk_in    (core_clk_in),
    .reset_in       (reset_in),
    .sample_tick_in (sample_tick_in),
    .level_in       (left_lvl),
    .mute_in        (tone_mute),
    .sample_in      (tone_raw_reg),
    .sample_out     (tone_left)
  );

  tsg_tone_scale #(
    .SAMPLE_W (SAMPLE_W)
  ) u_scale_right (
    .core_clk_in    (core_clk_in),
    .reset_in       (reset_in),
    .sample_tick_in (sample_tick_in),
    .level_in       (right_lvl),
    .mute_in        (tone_mute),
    .sample_in      (tone_raw_reg),
    .sample_out     (tone_right)
  );

  // The playback side has passed its own volume stage, so its level never touches the tone.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mix_left_out  <= '0;
      mix_right_out <= '0;
    end else if (sample_tick_in) begin
      mix_left_out  <= sat(OW'(play_left_in) + OW'(tone_left));
      mix_right_out <= sat(OW'(play_right_in) + OW'(tone_right));
    end
  end

  assign tone_active_out = enable_reg;

  // Read mux; unmapped offsets answer zero.
  always_comb begin
    case (link.reg_addr)
      TSG_OFS_LEFT_CTL:  rd_val = {enable_reg, left_ctl_reg[TSG_ENABLE_BIT-1:0]};
      TSG_OFS_RIGHT_CTL: rd_val = right_ctl_reg;
      TSG_OFS_LEN_HI:    rd_val = len_hi_reg;
      TSG_OFS_LEN_MID:   rd_val = len_mid_reg;
      TSG_OFS_LEN_LO:    rd_val = len_lo_reg;
      TSG_OFS_SIN_HI:    rd_val = sin_hi_reg;
      TSG_OFS_SIN_LO:    rd_val = sin_lo_reg;
      TSG_OFS_COS_HI:    rd_val = cos_hi_reg;
      TSG_OFS_COS_LO:    rd_val = cos_lo_reg;
      default:           rd_val = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= link.reg_rd ? rd_val : '0;
    end
  end

  assign link.reg_rdata = rdata_reg;

endmodule

/* rtl/tsg_tone_host.sv */
// Tone controller: software registers, configuration load and click insertion sequence.
`timescale 1ns/1ns
module tsg_tone_host (
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        reset_in,
  // Register link to the tone generator
  tsg_link_if.host                         link,
  // Software port
  input  wire logic [7:0]                  sw_addr_in,
  input  wire logic [tsg_pkg::TSG_SW_W-1:0] sw_wdata_in,
  input  wire logic                        sw_wr_in,
  input  wire logic                        sw_rd_in,
  output logic [tsg_pkg::TSG_SW_W-1:0]     sw_rdata_out,
  // Playback path control
  input  wire logic [1:0]                  dac_gain_flags_in,
  output logic                             dac_mute_out,
  output logic                             dac_divider_on_out
);
  import tsg_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE, H_LOAD, H_MUTE, H_WAIT_GAIN, H_DIV_OFF, H_ENABLE,
    H_DIV_ON, H_UNMUTE, H_POLL_RD, H_POLL_WAIT, H_POLL_CAP
  } tsg_host_state_e;

  tsg_host_state_e       state_reg;
  logic [TSG_COEF_W-1:0] sine_reg;
  logic [TSG_COEF_W-1:0] cos_reg;
  logic [TSG_LEN_W-1:0]  len_reg;
  logic [15:0]           vol_reg;
  logic [3:0]            idx_reg;
  logic                  tone_seen_reg;
  logic                  cmd_wr;
  logic                  busy;

  // Byte sent for each tone register, in offset order; enable is left clear.
  function automatic logic [7:0] cfg_byte(input logic [3:0] i, input logic [15:0] v,
                                          input logic [TSG_LEN_W-1:0] l, input logic [15:0] s,
                                          input logic [15:0] c);
    case (i)
      4'h0:    return {2'h0, v[TSG_LEVEL_MSB:0]};
      4'h1:    return v[TSG_VOL_RIGHT_LSB+7:TSG_VOL_RIGHT_LSB];
      4'h2:    return l[23:16];
      4'h3:    return l[15:8];
      4'h4:    return l[7:0];
      4'h5:    return s[15:8];
      4'h6:    return s[7:0];
      4'h7:    return c[15:8];
      default: return c[7:0];
    endcase
  endfunction

  assign busy   = (state_reg != H_IDLE);
  assign cmd_wr = sw_wr_in && (sw_addr_in == TSG_HOST_CMD) && !busy;

  // Settings are held at their exact widths, so unused upper bits reach the device as zero.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sine_reg <= {TSG_RST_SIN_HI, TSG_RST_SIN_LO};
      cos_reg  <= {TSG_RST_COS_HI, TSG_RST_COS_LO};
      len_reg  <= {TSG_RST_LEN_HI, TSG_RST_LEN_MID, TSG_RST_LEN_LO};
      vol_reg  <= '0;
    end else if (sw_wr_in && !busy) begin
      case (sw_addr_in)
        TSG_HOST_SINE:   sine_reg <= sw_wdata_in[TSG_COEF_W-1:0];
        TSG_HOST_COSINE: cos_reg  <= sw_wdata_in[TSG_COEF_W-1:0];
        TSG_HOST_LENGTH: len_reg  <= sw_wdata_in[TSG_LEN_W-1:0];
        TSG_HOST_VOLUME: vol_reg  <= sw_wdata_in[15:0];
        default: ;
      endcase
    end
  end

  // Sequencer. Loading happens ahead of time; a click then needs only the short trigger.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= H_IDLE;
      idx_reg   <= '0;
    end else begin
      case (state_reg)
        H_IDLE: begin
          idx_reg <= '0;
          if (cmd_wr && sw_wdata_in[TSG_CMD_LOAD_BIT]) begin
            state_reg <= H_LOAD;
          end else if (cmd_wr && sw_wdata_in[TSG_CMD_BEEP_BIT]) begin
            state_reg <= H_MUTE;
          end else if (cmd_wr && sw_wdata_in[TSG_CMD_POLL_BIT]) begin
            state_reg <= H_POLL_RD;
          end
        end
        H_LOAD: begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == TSG_CFG_COUNT - 4'h1) begin
            state_reg <= H_IDLE;
          end
        end
        H_MUTE:      state_reg <= H_WAIT_GAIN;
        H_WAIT_GAIN: begin
          if (dac_gain_flags_in == TSG_GAIN_FLAGS_SET) begin
            state_reg <= H_DIV_OFF;
          end
        end
        H_DIV_OFF:   state_reg <= H_ENABLE;
        H_ENABLE:    state_reg <= H_DIV_ON;
        H_DIV_ON:    state_reg <= H_UNMUTE;
        H_UNMUTE:    state_reg <= H_IDLE;
        H_POLL_RD:   state_reg <= H_POLL_WAIT;
        H_POLL_WAIT: state_reg <= H_POLL_CAP;
        H_POLL_CAP:  state_reg <= H_IDLE;
        default:     state_reg <= H_IDLE;
      endcase
    end
  end

  // The divider is stopped around the enable, so serial clocks must not come from it.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dac_mute_out       <= 1'b0;
      dac_divider_on_out <= 1'b1;
    end else if (state_reg == H_MUTE) begin
      dac_mute_out <= 1'b1;
    end else if (state_reg == H_DIV_OFF) begin
      dac_divider_on_out <= 1'b0;
    end else if (state_reg == H_DIV_ON) begin
      dac_divider_on_out <= 1'b1;
    end else if (state_reg == H_UNMUTE) begin
      dac_mute_out <= 1'b0;
    end
  end

  // Link strobes come from flip-flops; reg_rd and the trigger write last one cycle, a load holds reg_wr for nine cycles.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      link.reg_wr    <= 1'b0;
      link.reg_rd    <= 1'b0;
      link.reg_addr  <= '0;
      link.reg_wdata <= '0;
    end else begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      if (state_reg == H_LOAD) begin
        link.reg_wr    <= 1'b1;
        link.reg_addr  <= TSG_OFS_LEFT_CTL + {4'h0, idx_reg};
        link.reg_wdata <= cfg_byte(idx_reg, vol_reg, len_reg, sine_reg, cos_reg);
      end else if (state_reg == H_ENABLE) begin
        link.reg_wr    <= 1'b1;
        link.reg_addr  <= TSG_OFS_LEFT_CTL;
        link.reg_wdata <= {1'b1, 1'b0, vol_reg[TSG_LEVEL_MSB:0]};
      end else if (state_reg == H_POLL_RD) begin
        link.reg_rd   <= 1'b1;
        link.reg_addr <= TSG_OFS_LEFT_CTL;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tone_seen_reg <= 1'b0;
    end else if (state_reg == H_POLL_CAP) begin
      tone_seen_reg <= link.reg_rdata[TSG_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sw_rdata_out <= '0;
    end else if (!sw_rd_in) begin
      sw_rdata_out <= '0;
    end else begin
      case (sw_addr_in)
        TSG_HOST_SINE:   sw_rdata_out <= TSG_SW_W'(sine_reg);
        TSG_HOST_COSINE: sw_rdata_out <= TSG_SW_W'(cos_reg);
        TSG_HOST_LENGTH: sw_rdata_out <= TSG_SW_W'(len_reg);
        TSG_HOST_VOLUME: sw_rdata_out <= TSG_SW_W'(vol_reg);
        TSG_HOST_STATUS: sw_rdata_out <= TSG_SW_W'({tone_seen_reg, busy});
        default:         sw_rdata_out <= '0;
      endcase
    end
  end

endmodule

/* rtl/tsg_tone_scale.sv */
// Per-channel tone level stage: 1 dB steps from +2 dB downward.
`timescale 1ns/1ns
module tsg_tone_scale #(
  parameter int SAMPLE_W = tsg_pkg::TSG_SAMPLE_W
) (
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_in,
  // Sample timing and level
  input  wire logic                       sample_tick_in,
  input  wire logic [5:0]                 level_in,
  input  wire logic                       mute_in,
  // Samples
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  output logic signed [SAMPLE_W-1:0]      sample_out
);
  import tsg_pkg::*;

  localparam int PW = SAMPLE_W + 17;
  localparam logic signed [PW-1:0] MAXV = PW'(2 ** (SAMPLE_W - 1) - 1);
  localparam logic signed [PW-1:0] MINV = -PW'(2 ** (SAMPLE_W - 1));

  logic [5:0]              rem_lvl;
  logic [5:0]              shift_lvl;
  logic signed [PW-1:0]    product;
  logic signed [PW-1:0]    scaled;

  // Six codes make about one halving, so a small mantissa table and a shift cover all 64 codes.
  assign rem_lvl   = level_in % TSG_DB_PER_HALVING;
  assign shift_lvl = level_in / TSG_DB_PER_HALVING;
  assign product   = PW'(sample_in) * $signed({1'b0, tsg_gain_mant(rem_lvl)});
  assign scaled    = product >>> (TSG_GAIN_FRAC + int'(shift_lvl));

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sample_out <= '0;
    end else if (sample_tick_in) begin
      if (mute_in) begin
        sample_out <= '0;
      end else if (scaled > MAXV) begin
        sample_out <= MAXV[SAMPLE_W-1:0];
      end else if (scaled < MINV) begin
        sample_out <= MINV[SAMPLE_W-1:0];
      end else begin
        sample_out <= scaled[SAMPLE_W-1:0];
      end
    end
  end

endmodule

/* testbench/test_sine_beep_generator.sv */
// Self-checking bench joining the tone controller and the tone generator.
`timescale 1ns/1ns
module test_sine_beep_generator;
  import tsg_pkg::*;
  logic               core_clk_in = 1'b0;
  logic               reset_in = 1'b1;
  logic [7:0]         sw_addr_in = 8'h00;
  logic [31:0]        sw_wdata_in = 32'h0;
  logic               sw_wr_in = 1'b0;
  logic               sw_rd_in = 1'b0;
  logic [31:0]        sw_rdata_out;
  logic [31:0]        rd;
  logic [1:0]         dac_gain_flags_in = 2'h0;
  logic               dac_mute_out;
  logic               dac_divider_on_out;
  logic               sample_tick_in = 1'b0;
  logic signed [15:0] play_in = 16'sh0123;
  logic signed [15:0] mix_l;
  logic signed [15:0] mix_r;
  logic signed [15:0] pk_l = 16'sh0;
  logic signed [15:0] pk_r = 16'sh0;
  logic               tone_active_out;
  logic               diff = 1'b0;
  int                 error_cnt = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  int                 ticks = 0;
  tsg_link_if link();
  tsg_tone_host i_tsg_tone_host (.core_clk_in(core_clk_in), .reset_in(reset_in), .link(link),
    .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in),
    .sw_rdata_out(sw_rdata_out), .dac_gain_flags_in(dac_gain_flags_in), .dac_mute_out(dac_mute_out),
    .dac_divider_on_out(dac_divider_on_out));
  tsg_tone_device i_tsg_tone_device (.core_clk_in(core_clk_in), .reset_in(reset_in), .link(link),
    .sample_tick_in(sample_tick_in), .play_left_in(play_in), .play_right_in(play_in),
    .mix_left_out(mix_l), .mix_right_out(mix_r), .tone_active_out(tone_active_out));
  tsg_link_props i_tsg_link_props (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata));
  always #5 core_clk_in = ~core_clk_in;
  // Ticks every fourth cycle leave room for the two-cycle spacing the generator prefers.
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    sample_tick_in <= (cyc % 4 == 0);
    if (tone_active_out && sample_tick_in) ticks <= ticks + 1;
    if (tone_active_out && (mix_l !== play_in || mix_r !== play_in)) diff <= 1'b1;
    if (tone_active_out && mix_l > pk_l) pk_l <= mix_l;
    if (tone_active_out && mix_r > pk_r) pk_r <= mix_r;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    sw_addr_in <= a;
    sw_wdata_in <= d;
    sw_wr_in <= 1'b1;
    @(posedge core_clk_in);
    sw_wr_in <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a);
    @(posedge core_clk_in);
    sw_addr_in <= a;
    sw_rd_in <= 1'b1;
    @(posedge core_clk_in);
    sw_rd_in <= 1'b0;
    #1 rd = sw_rdata_out;
  endtask
  task automatic cmd_wait(input logic [31:0] c);
    sw_write(TSG_HOST_CMD, c);
    for (int i = 0; i < 300; i++) begin
      sw_read(TSG_HOST_STATUS);
      if (rd[0] === 1'b0) break;
    end
    chk(rd[0], 1'b0);
  endtask
  task automatic tone_off();
    for (int i = 0; i < 3000 && tone_active_out !== 1'b0; i++) @(posedge core_clk_in);
    chk(tone_active_out, 1'b0);
  endtask
  task automatic t_reset();
    sw_read(TSG_HOST_SINE);
    chk(rd, 32'h10D8);
    sw_read(TSG_HOST_COSINE);
    chk(rd, 32'h7EE3);
    sw_read(TSG_HOST_LENGTH);
    chk(rd, 32'h0000EE);
    sw_read(TSG_HOST_VOLUME);
    chk(rd, 32'h0);
  endtask
  // A trigger with no load plays the generator's own reset length.
  task automatic t_default();
    ticks = 0;
    dac_gain_flags_in <= TSG_GAIN_FLAGS_SET;
    cmd_wait(32'h2);
    tone_off();
    chk(ticks, 32'd238);
  endtask
  // A held-off gain flag must keep the enable back after the playback path is muted, with the divider still running.
  task automatic t_beep(input logic [31:0] vol, input logic exp_diff, input logic exp_eq);
    sw_write(TSG_HOST_COSINE, 32'h7EE3);
    sw_write(TSG_HOST_LENGTH, 32'd40);
    sw_write(TSG_HOST_VOLUME, vol);
    cmd_wait(32'h1);
    ticks = 0;
    diff = 1'b0;
    pk_l = 16'sh0;
    pk_r = 16'sh0;
    dac_gain_flags_in <= 2'h0;
    sw_write(TSG_HOST_CMD, 32'h2);
    repeat (20) @(posedge core_clk_in);
    chk({dac_mute_out, dac_divider_on_out, tone_active_out}, 3'b110);
    dac_gain_flags_in <= TSG_GAIN_FLAGS_SET;
    cmd_wait(32'h0);
    chk({dac_mute_out, dac_divider_on_out}, 2'b01);
    cmd_wait(32'h4);
    sw_read(TSG_HOST_STATUS);
    chk(rd[1], 1'b1);
    tone_off();
    chk(ticks, 32'd40);
    chk(diff, exp_diff);
    chk(pk_l == pk_r, exp_eq);
    cmd_wait(32'h4);
    sw_read(TSG_HOST_STATUS);
    chk(rd[1], 1'b0);
    // The tone pipeline needs three ticks to drain after the burst ends.
    repeat (16) @(posedge core_clk_in);
    chk(mix_l, play_in);
    chk(mix_r, play_in);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_default();
    t_beep(32'h0000_0300, 1'b1, 1'b0);
    t_beep(32'h0000_C000, 1'b0, 1'b1);
    t_beep(32'h0000_4008, 1'b1, 1'b1);
    t_beep(32'h0000_8003, 1'b1, 1'b1);
    end_of_test();
  end
endmodule

/* testbench/tsg_link_props.sv */
// Assertions on the register link between the tone controller and the tone generator.
`timescale 1ns/1ns
module tsg_link_props (
  // Clock and reset
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  // Link signals
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence cfg_tail;
    wr_at(8'h48) ##1 wr_at(8'h49) ##1 wr_at(8'h4A) ##1 wr_at(8'h4B) ##1
    wr_at(8'h4C) ##1 wr_at(8'h4D) ##1 wr_at(8'h4E) ##1 wr_at(8'h4F);
  endsequence
  AST_ONE_STROBE: assert property (!(reg_wr && reg_rd)) else $error("link strobes overlap");
  AST_WR_RANGE: assert property (reg_wr |-> reg_addr inside {[8'h47:8'h4F]}) else $error("write off map");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stale read data");
  AST_LOAD_ORDER: assert property (wr_at(8'h47) ##0 !reg_wdata[7] |=> cfg_tail) else $error("load order");
  AST_EN_FIELD: assert property (wr_at(8'h47) ##0 reg_wdata[7] |-> !reg_wdata[6]) else $error("enable field");
  AST_TRIGGER_ONLY: assert property (wr_at(8'h47) ##0 reg_wdata[7] |=> !reg_wr [*2]) else $error("extra write");
  AST_RD_ENABLE: assert property (reg_rd |-> reg_addr == 8'h47) else $error("poll address");
  AST_POLL_FIELD: assert property (reg_rd |=> reg_rdata[6] == 1'b0) else $error("poll field");
endmodule
